/* File: fcsr_regs.sv */
`timescale 1ns/100ps
// What this block does
// - Boot loads working config from persistent word
// - Volatile config writes update working config immediately
// - Status bit 7 is the write-protect control
// - Bit 7 plus low pin blocks status writes
// - Status bit 5 selects top or bottom region
// - Bulk erase only with all protect bits zero
// - Write latch clear at power-up, needed first
// - Status bit 0 shows busy during cycles
// - Reset clears volatile status bits
// - Read-status returns, write-status updates status
// - Config 15:12 sets dummy count, 0/15 default
// - Config 11:9 picks boot execute-in-place mode
// - Config bit 4 enables hold/reset pin
// - Config bit 3 low selects four-line protocol
// - Config bit 2 low selects two-line protocol when bit 3 is high
// - Config bit 0 low locks persistent word
// - Persistent word delivered as all ones
module fcsr_regs #(
  parameter int         SEC_HI        = 22,
  parameter int         SEC_LO        = 16,
  parameter logic [3:0] DUMMY_DEF_CNT = 4'ha
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic       mosi_i,
  input  wire logic       wp_n_i,
  output logic            miso_o,
  output logic            miso_oe_o,
  output logic            busy_o,
  output logic [3:0]      dummy_cnt_o,
  output logic [2:0]      xip_mode_o,
  output logic            xip_en_o,
  output logic            hold_en_o,
  output logic            quad_o,
  output logic            dual_o
);

  localparam int SW = SEC_HI - SEC_LO + 1;

  // ***************************************************
  // Link side, on the serial clock
  // ***************************************************
  typedef struct packed {
    logic [7:0]    opc;
    logic [23:0]   sh;
    logic [SW-1:0] sec;
    logic [5:0]    len;
    logic [15:0]   out;
    logic          rd;
    logic          tg;
  } fcsr_lnk_t;

  fcsr_lnk_t  l_q;
  fcsr_lnk_t  l_d;
  logic [5:0] cnt_q;
  logic       lmiso_q;
  logic       loe_q;
  logic [7:0] stat_rd;
  logic [15:0] nv_rd;

  // Bit counter, cleared while the frame is idle
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      cnt_q <= 6'h00;
    end else if (cnt_q != fcsr_pkg::LEN_MAX) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  // Shift in command, address and data; load read data
  always_comb begin
    l_d     = l_q;
    l_d.sh  = {l_q.sh[22:0], mosi_i};
    l_d.len = (cnt_q == fcsr_pkg::LEN_MAX) ? cnt_q : cnt_q + 6'h01;
    l_d.out = {l_q.out[14:0], 1'b0};
    if (cnt_q == 6'h00) begin
      l_d.tg = ~l_q.tg;
      l_d.rd = 1'b0;
    end
    if (cnt_q == 6'h07) begin
      l_d.opc = l_d.sh[7:0];
      l_d.rd  = (l_d.sh[7:0] == fcsr_pkg::OP_RDSR) || (l_d.sh[7:0] == fcsr_pkg::OP_RDNV);
    end
    if (cnt_q == 6'h1f) begin
      l_d.sec = l_d.sh[SEC_HI:SEC_LO];
    end
    if (cnt_q == 6'h07 && l_d.sh[7:0] == fcsr_pkg::OP_RDSR) begin
      l_d.out = {stat_rd, 8'h00};
    end else if (cnt_q == 6'h07 && l_d.sh[7:0] == fcsr_pkg::OP_RDNV) begin
      l_d.out = nv_rd;
    end else if (cnt_q > 6'h07 && cnt_q[2:0] == 3'h7 && l_q.opc == fcsr_pkg::OP_RDSR) begin
      l_d.out = {stat_rd, 8'h00};
    end else if (cnt_q > 6'h07 && cnt_q[3:0] == 4'h7 && l_q.opc == fcsr_pkg::OP_RDNV) begin
      l_d.out = nv_rd;
    end
  end

  // Link state register; cleared by power-on so toggle and opcode start known
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // Read data leaves on the falling edge
  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      lmiso_q <= 1'b0;
      loe_q   <= 1'b0;
    end else begin
      lmiso_q <= l_q.out[15];
      loe_q   <= l_q.rd;
    end
  end

  assign miso_o    = lmiso_q;
  assign miso_oe_o = loe_q;

  // ***************************************************
  // Register side, on the reference clock
  // ***************************************************
  typedef struct packed {
    logic                 cs_s1;
    logic                 cs_s2;
    logic                 cs_s3;
    logic                 tg_s1;
    logic                 tg_s2;
    logic                 tg_seen;
    logic                 wp_s1;
    logic                 wp_s2;
    fcsr_pkg::fcsr_state_t st;
    logic [5:0]           srnv;
    logic                 wel;
    logic                 busy;
    logic [11:0]          tmr;
    logic [15:0]          nvcr;
    logic [3:0]           wdum;
    logic [2:0]           wxip;
    logic                 whold;
    logic                 wquad_n;
    logic                 wdual_n;
    logic [3:0]           dum_o;
    logic                 xen_o;
    logic                 quad_o;
    logic                 dual_o;
  } fcsr_reg_t;

  fcsr_reg_t r_q;
  fcsr_reg_t r_d;
  logic      fe;
  logic      wp_lock;
  logic      okw;
  logic      hit;
  logic      start;
  logic [3:0] bp;
  logic [7:0] nprot;
  logic [7:0] secx;

  assign stat_rd = {r_q.srnv, r_q.wel, r_q.busy};
  assign nv_rd   = r_q.nvcr;

  // Frame end, protection and region decode
  always_comb begin
    fe      = r_q.cs_s2 & ~r_q.cs_s3 & (r_q.tg_s2 != r_q.tg_seen);
    wp_lock = r_q.srnv[fcsr_pkg::SR_SRWD-2] & ~r_q.wp_s2;
    okw     = r_q.wel & (r_q.st == fcsr_pkg::ST_IDLE);
    bp      = {r_q.srnv[fcsr_pkg::SR_BP3-2], r_q.srnv[fcsr_pkg::SR_BP_HI-2:fcsr_pkg::SR_BP_LO-2]};
    nprot   = (bp == 4'h0) ? 8'h00 : (bp >= 4'h8) ? 8'h80 : 8'(8'h01 << (bp - 4'h1));
    secx    = 8'(l_q.sec);
    if (r_q.srnv[fcsr_pkg::SR_TB-2]) begin
      hit = secx < nprot;
    end else begin
      hit = (nprot != 8'h00) && (secx >= 8'h80 - nprot);
    end
  end

  // Command execution and busy sequencing
  always_comb begin
    r_d         = r_q;
    start       = 1'b0;
    r_d.cs_s1   = cs_n_i;
    r_d.cs_s2   = r_q.cs_s1;
    r_d.cs_s3   = r_q.cs_s2;
    r_d.tg_s1   = l_q.tg;
    r_d.tg_s2   = r_q.tg_s1;
    r_d.wp_s1   = wp_n_i;
    r_d.wp_s2   = r_q.wp_s1;
    // Track the frame toggle while deselected; a reset cannot leave it out of step
    if (r_q.cs_s2 & r_q.cs_s3) begin
      r_d.tg_seen = r_q.tg_s2;
    end
    case (r_q.st)
      fcsr_pkg::ST_BOOT: begin
        r_d.wdum    = r_q.nvcr[fcsr_pkg::NV_DUM_HI:fcsr_pkg::NV_DUM_LO];
        r_d.wxip    = r_q.nvcr[fcsr_pkg::NV_XIP_HI:fcsr_pkg::NV_XIP_LO];
        r_d.whold   = r_q.nvcr[fcsr_pkg::NV_HOLD];
        r_d.wquad_n = r_q.nvcr[fcsr_pkg::NV_QUAD];
        r_d.wdual_n = r_q.nvcr[fcsr_pkg::NV_DUAL];
        r_d.st      = fcsr_pkg::ST_IDLE;
      end
      fcsr_pkg::ST_IDLE: begin
        if (fe) begin
          case (l_q.opc)
            fcsr_pkg::OP_WREN: r_d.wel = 1'b1;
            fcsr_pkg::OP_WRDI: r_d.wel = 1'b0;
            fcsr_pkg::OP_WRSR: begin
              if (okw && !wp_lock && l_q.len == fcsr_pkg::LEN_SR) begin
                r_d.srnv = l_q.sh[7:2];
                r_d.tmr  = 12'(fcsr_pkg::C_WRSR - 1);
                start    = 1'b1;
              end
            end
            fcsr_pkg::OP_WRNV: begin
              if (okw && r_q.nvcr[fcsr_pkg::NV_LOCK] && l_q.len == fcsr_pkg::LEN_NV) begin
                r_d.nvcr = l_q.sh[15:0];
                r_d.tmr  = 12'(fcsr_pkg::C_WRNV - 1);
                start    = 1'b1;
              end
            end
            fcsr_pkg::OP_WRVC: begin
              if (okw && l_q.len == fcsr_pkg::LEN_SR) begin
                r_d.wdum = l_q.sh[fcsr_pkg::VC_DUM_HI:fcsr_pkg::VC_DUM_LO];
                r_d.wxip = l_q.sh[fcsr_pkg::VC_XIP] ? fcsr_pkg::XIP_OFF : fcsr_pkg::XIP_FAST;
                r_d.wel  = 1'b0;
              end
            end
            fcsr_pkg::OP_WREV: begin
              if (okw && l_q.len == fcsr_pkg::LEN_SR) begin
                r_d.wquad_n = l_q.sh[fcsr_pkg::EV_QUAD];
                r_d.wdual_n = l_q.sh[fcsr_pkg::EV_DUAL];
                r_d.wel     = 1'b0;
              end
            end
            fcsr_pkg::OP_PROG: begin
              if (okw && !hit && l_q.len >= fcsr_pkg::LEN_PRG) begin
                r_d.tmr = 12'(fcsr_pkg::C_PROG - 1);
                start   = 1'b1;
              end
            end
            fcsr_pkg::OP_SERS: begin
              if (okw && !hit && l_q.len == fcsr_pkg::LEN_ADR) begin
                r_d.tmr = 12'(fcsr_pkg::C_SE - 1);
                start   = 1'b1;
              end
            end
            fcsr_pkg::OP_BERS: begin
              if (okw && bp == 4'h0 && l_q.len == fcsr_pkg::LEN_OP) begin
                r_d.tmr = 12'(fcsr_pkg::C_BE - 1);
                start   = 1'b1;
              end
            end
            default: r_d.wel = r_q.wel;
          endcase
        end
        if (start) begin
          r_d.st   = fcsr_pkg::ST_BUSY;
          r_d.busy = 1'b1;
          r_d.wel  = 1'b0;
        end
      end
      fcsr_pkg::ST_BUSY: begin
        if (r_q.tmr == 12'h000) begin
          r_d.st   = fcsr_pkg::ST_IDLE;
          r_d.busy = 1'b0;
        end else begin
          r_d.tmr = r_q.tmr - 12'h001;
        end
      end
      default: r_d.st = fcsr_pkg::ST_BOOT;
    endcase
    // Registered views of the working configuration
    r_d.dum_o = (r_d.wdum == fcsr_pkg::DUM_CODE_A || r_d.wdum == fcsr_pkg::DUM_CODE_B)
                ? DUMMY_DEF_CNT : r_d.wdum;
    r_d.xen_o  = r_d.wxip < fcsr_pkg::XIP_RSV_A;
    r_d.quad_o = ~r_d.wquad_n;
    r_d.dual_o = ~r_d.wdual_n & r_d.wquad_n;
  end

  // Register side state; reset is power-on
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      r_q         <= '0;
      r_q.cs_s1   <= 1'b1;
      r_q.cs_s2   <= 1'b1;
      r_q.cs_s3   <= 1'b1;
      r_q.st      <= fcsr_pkg::ST_BOOT;
      r_q.srnv    <= fcsr_pkg::SR_NV_RST;
      r_q.wel     <= 1'b0;
      r_q.busy    <= 1'b0;
      r_q.nvcr    <= fcsr_pkg::NV_RST;
      r_q.wdum    <= fcsr_pkg::NV_RST[fcsr_pkg::NV_DUM_HI:fcsr_pkg::NV_DUM_LO];
      r_q.wxip    <= fcsr_pkg::NV_RST[fcsr_pkg::NV_XIP_HI:fcsr_pkg::NV_XIP_LO];
      r_q.whold   <= fcsr_pkg::NV_RST[fcsr_pkg::NV_HOLD];
      r_q.wquad_n <= fcsr_pkg::NV_RST[fcsr_pkg::NV_QUAD];
      r_q.wdual_n <= fcsr_pkg::NV_RST[fcsr_pkg::NV_DUAL];
      r_q.dum_o   <= DUMMY_DEF_CNT;
    end else begin
      r_q <= r_d;
    end
  end

  assign busy_o      = r_q.busy;
  assign dummy_cnt_o = r_q.dum_o;
  assign xip_mode_o  = r_q.wxip;
  assign xip_en_o    = r_q.xen_o;
  assign hold_en_o   = r_q.whold;
  assign quad_o      = r_q.quad_o;
  assign dual_o      = r_q.dual_o;

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  chk_boot_load: assert property (r_q.st == fcsr_pkg::ST_BOOT |=> hold_en_o == $past(r_q.nvcr[4]))
    else $error("working config not loaded at boot");
  chk_vcr_copy: assert property (fe && okw && l_q.opc == fcsr_pkg::OP_WRVC && l_q.len == 6'h10 |=> r_q.wdum == $past(l_q.sh[7:4]))
    else $error("volatile write not copied");
  chk_sr_locked: assert property (fe && wp_lock |=> $stable(r_q.srnv))
    else $error("status written while locked");
  chk_region_refuse: assert property (start |-> !hit || l_q.opc == fcsr_pkg::OP_BERS || l_q.opc == fcsr_pkg::OP_WRSR || l_q.opc == fcsr_pkg::OP_WRNV)
    else $error("protected region accepted");
  chk_bulk_guard: assert property (start && l_q.opc == fcsr_pkg::OP_BERS |-> bp == 4'h0)
    else $error("bulk erase with protect bits set");
  chk_wel_needed: assert property (start |-> r_q.wel ##1 !r_q.wel)
    else $error("cycle started without write latch");
  chk_busy_span: assert property (start |=> busy_o [*2])
    else $error("busy not shown during cycle");
  chk_busy_clear: assert property (r_q.st == fcsr_pkg::ST_BUSY && r_q.tmr == 12'h000 |=> !busy_o && r_q.st == fcsr_pkg::ST_IDLE)
    else $error("busy not cleared at end");
  chk_reset_vol: assert property (disable iff (1'b0) rst_i |=> !busy_o && !r_q.wel && r_q.nvcr == 16'hffff)
    else $error("reset values wrong");
  chk_dummy_map: assert property ((r_q.wdum == 4'h0 || r_q.wdum == 4'hf) |-> dummy_cnt_o == DUMMY_DEF_CNT)
    else $error("dummy default not applied");
  chk_nv_lock: assert property (!r_q.nvcr[0] |=> $stable(r_q.nvcr))
    else $error("locked persistent word changed");
  chk_proto_map: assert property (quad_o |-> !dual_o && r_q.wquad_n == 1'b0)
    else $error("protocol select wrong");
  chk_rd_status: assert property (@(posedge sck_i) cnt_q == 6'h07 && l_d.opc == fcsr_pkg::OP_RDSR |=> l_q.out[15:8] == $past(stat_rd))
    else $error("status not loaded for read");

  cov_wrsr: cover property (start && l_q.opc == fcsr_pkg::OP_WRSR);
  cov_prog_refused: cover property (fe && okw && l_q.opc == fcsr_pkg::OP_PROG && hit);
  cov_nv_write: cover property (start && l_q.opc == fcsr_pkg::OP_WRNV);
  cov_bulk: cover property (start && l_q.opc == fcsr_pkg::OP_BERS);

endmodule

/* File: fcsr_pkg.sv */
package fcsr_pkg;

  // ***************************************************
  // Command opcodes
  // ***************************************************
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_RDNV = 8'hb5;
  localparam logic [7:0] OP_WRNV = 8'hb1;
  localparam logic [7:0] OP_WRVC = 8'h81;
  localparam logic [7:0] OP_WREV = 8'h61;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_SERS = 8'hd8;
  localparam logic [7:0] OP_BERS = 8'hc7;

  // ***************************************************
  // Frame lengths in bits
  // ***************************************************
  localparam logic [5:0] LEN_OP  = 6'h08;
  localparam logic [5:0] LEN_SR  = 6'h10;
  localparam logic [5:0] LEN_NV  = 6'h18;
  localparam logic [5:0] LEN_ADR = 6'h20;
  localparam logic [5:0] LEN_PRG = 6'h28;
  localparam logic [5:0] LEN_MAX = 6'h3f;

  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int SR_SRWD   = 7;
  localparam int SR_BP3    = 6;
  localparam int SR_TB     = 5;
  localparam int SR_BP_HI  = 4;
  localparam int SR_BP_LO  = 2;
  localparam int NV_DUM_HI = 15;
  localparam int NV_DUM_LO = 12;
  localparam int NV_XIP_HI = 11;
  localparam int NV_XIP_LO = 9;
  localparam int NV_HOLD   = 4;
  localparam int NV_QUAD   = 3;
  localparam int NV_DUAL   = 2;
  localparam int NV_LOCK   = 0;
  localparam int VC_DUM_HI = 7;
  localparam int VC_DUM_LO = 4;
  localparam int VC_XIP    = 3;
  localparam int EV_QUAD   = 7;
  localparam int EV_DUAL   = 6;

  // ***************************************************
  // Reset values and codes
  // ***************************************************
  localparam logic [15:0] NV_RST    = 16'hffff;
  localparam logic [5:0]  SR_NV_RST = 6'h00;
  localparam logic [3:0]  DUM_CODE_A = 4'h0;
  localparam logic [3:0]  DUM_CODE_B = 4'hf;
  localparam logic [2:0]  XIP_FAST  = 3'h0;
  localparam logic [2:0]  XIP_RSV_A = 3'h5;
  localparam logic [2:0]  XIP_OFF   = 3'h7;

  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_MHZ   = 100;
  localparam int T_WRSR_NS = 1000;
  localparam int T_WRNV_NS = 1000;
  localparam int T_PROG_NS = 5000;
  localparam int T_SE_NS   = 20000;
  localparam int T_BE_NS   = 40000;
  localparam int C_WRSR = (T_WRSR_NS * CLK_MHZ + 999) / 1000;
  localparam int C_WRNV = (T_WRNV_NS * CLK_MHZ + 999) / 1000;
  localparam int C_PROG = (T_PROG_NS * CLK_MHZ + 999) / 1000;
  localparam int C_SE   = (T_SE_NS * CLK_MHZ + 999) / 1000;
  localparam int C_BE   = (T_BE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_BUSY} fcsr_state_t;

endpackage

/* File: fcsr_spi_host.sv */
`timescale 1ns/100ps
module fcsr_spi_host (
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_i
);
  // ***************************************************
  // Idle levels
  // ***************************************************
  // Clock low and chip deselected between frames
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // ***************************************************
  // Frame engine
  // ***************************************************
  // Mode 0 frame, MSB first, 12 ns link clock only inside the frame
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    #3 cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi_o = tx[i];
      #6 sck_o = 1'b1;
      rx = {rx[62:0], miso_oe_i ? miso_i : ~rx[0]}; // Undriven line reads no stale bit
      #6 sck_o = 1'b0;
    end
    #6 cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // Released data line shows no stale value
    #100; // Deselect gap lets the command take effect
  endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench;
  localparam logic [3:0] DEF_CNT = 4'ha;
  logic        ref_clk_i;
  logic        rst_i;
  logic        wp_n_i;
  logic        sck;
  logic        cs_n;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  logic        busy_o;
  logic [3:0]  dummy_cnt_o;
  logic [2:0]  xip_mode_o;
  logic        xip_en_o;
  logic        hold_en_o;
  logic        quad_o;
  logic        dual_o;
  logic [15:0] v;
  int          err_count;
  int          total_checks;

  // ***************************************************
  // Design and link partner
  // ***************************************************
  fcsr_regs #(.DUMMY_DEF_CNT(DEF_CNT)) fcsr_regs_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi),
    .wp_n_i(wp_n_i), .miso_o(miso), .miso_oe_o(miso_oe), .busy_o(busy_o),
    .dummy_cnt_o(dummy_cnt_o), .xip_mode_o(xip_mode_o), .xip_en_o(xip_en_o),
    .hold_en_o(hold_en_o), .quad_o(quad_o), .dual_o(dual_o));
  fcsr_spi_host fcsr_spi_host_i (
    .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));

  // Reference clock 100 MHz
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // ***************************************************
  // Helpers
  // ***************************************************
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cmd(input logic [63:0] tx, input int n);
    logic [63:0] rx;
    fcsr_spi_host_i.xfer(tx, n, rx);
    @(posedge ref_clk_i);
  endtask

  // Read frame: opcode then zeros, returns the data field
  task automatic rd(input logic [7:0] op, input int n, output logic [15:0] d);
    logic [63:0] rx;
    fcsr_spi_host_i.xfer(64'(op) << (n - 8), n, rx);
    @(posedge ref_clk_i);
    d = (n == 16) ? {8'h00, rx[7:0]} : rx[15:0];
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 5000 && busy_o !== 1'b0; i++) @(posedge ref_clk_i);
    if (i == 5000) begin
      err_count++;
      end_of_test();
    end
  endtask

  // Write preceded by write enable, then busy seen on pin and in status
  task automatic wr(input logic [63:0] tx, input int n, input logic exp_busy);
    logic [15:0] s;
    cmd(64'(fcsr_pkg::OP_WREN), 8);
    cmd(tx, n);
    chk("busy pin", 16'(busy_o), 16'(exp_busy));
    rd(fcsr_pkg::OP_RDSR, 16, s);
    chk("status busy bit", 16'(s[0]), 16'(exp_busy));
    wait_idle();
  endtask

  task automatic reset_and_defaults();
    rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk("busy", 16'(busy_o), 16'h0000);
    chk("dummy", 16'(dummy_cnt_o), 16'(DEF_CNT));
    chk("xip mode", 16'(xip_mode_o), 16'h0007);
    chk("xip en", 16'(xip_en_o), 16'h0000);
    chk("hold", 16'(hold_en_o), 16'h0001);
    chk("quad", 16'(quad_o), 16'h0000);
    chk("dual", 16'(dual_o), 16'h0000);
    rd(fcsr_pkg::OP_RDSR, 16, v);
    chk("status", v, 16'h0000);
    rd(fcsr_pkg::OP_RDNV, 24, v);
    chk("persist", v, 16'hffff);
  endtask

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    rst_i = 1'b1;
    wp_n_i = 1'b1;
    err_count = 0;
    total_checks = 0;
    reset_and_defaults();
    // Latch gating and read-back
    cmd(64'({fcsr_pkg::OP_WRSR, 8'h9c}), 16);
    rd(fcsr_pkg::OP_RDSR, 16, v);
    chk("status no latch", v, 16'h0000);
    cmd(64'(fcsr_pkg::OP_WREN), 8);
    rd(fcsr_pkg::OP_RDSR, 16, v);
    chk("latch set", v, 16'h0002);
    cmd(64'(fcsr_pkg::OP_WRDI), 8);
    rd(fcsr_pkg::OP_RDSR, 16, v);
    chk("latch cleared", v, 16'h0000);
    // Top region of 64 sectors protected, write-protect control set
    wr(64'({fcsr_pkg::OP_WRSR, 8'h9c}), 16, 1'b1);
    rd(fcsr_pkg::OP_RDSR, 16, v);
    chk("status written", v, 16'h009c);
    wr(64'(fcsr_pkg::OP_BERS), 8, 1'b0);
    wr(64'({fcsr_pkg::OP_PROG, 24'h7f0000, 8'h55}), 40, 1'b0);
    wr(64'({fcsr_pkg::OP_SERS, 24'h400000}), 32, 1'b0);
    wr(64'({fcsr_pkg::OP_PROG, 24'h3f0000, 8'h55}), 40, 1'b1);
    // Hardware protected mode
    @(posedge ref_clk_i);
    wp_n_i <= 1'b0;
    wr(64'({fcsr_pkg::OP_WRSR, 8'h00}), 16, 1'b0);
    rd(fcsr_pkg::OP_RDSR, 16, v);
    chk("status locked", v & 16'h00fc, 16'h009c);
    @(posedge ref_clk_i);
    wp_n_i <= 1'b1;
    // Bottom region of one sector
    wr(64'({fcsr_pkg::OP_WRSR, 8'h24}), 16, 1'b1);
    wr(64'({fcsr_pkg::OP_PROG, 24'h00ffff, 8'haa}), 40, 1'b0);
    wr(64'({fcsr_pkg::OP_PROG, 24'h7f0000, 8'haa}), 40, 1'b1);
    wr(64'({fcsr_pkg::OP_WRSR, 8'h00}), 16, 1'b1);
    wr(64'(fcsr_pkg::OP_BERS), 8, 1'b1);
    // Volatile writes take effect at once
    wr(64'({fcsr_pkg::OP_WRVC, 8'h30}), 16, 1'b0);
    chk("dummy", 16'(dummy_cnt_o), 16'h0003);
    chk("xip mode", 16'(xip_mode_o), 16'h0000);
    chk("xip en", 16'(xip_en_o), 16'h0001);
    wr(64'({fcsr_pkg::OP_WRVC, 8'hf8}), 16, 1'b0);
    chk("dummy code f", 16'(dummy_cnt_o), 16'(DEF_CNT));
    chk("xip mode", 16'(xip_mode_o), 16'h0007);
    wr(64'({fcsr_pkg::OP_WRVC, 8'h08}), 16, 1'b0);
    chk("dummy code 0", 16'(dummy_cnt_o), 16'(DEF_CNT));
    wr(64'({fcsr_pkg::OP_WREV, 8'h40}), 16, 1'b0);
    chk("quad", 16'({quad_o, dual_o}), 16'h0002);
    wr(64'({fcsr_pkg::OP_WREV, 8'h80}), 16, 1'b0);
    chk("dual", 16'({quad_o, dual_o}), 16'h0001);
    // Persistent word write, then lock
    wr(64'({fcsr_pkg::OP_WRNV, 16'h18e2}), 24, 1'b1);
    rd(fcsr_pkg::OP_RDNV, 24, v);
    chk("persist", v, 16'h18e2);
    chk("dummy kept", 16'(dummy_cnt_o), 16'(DEF_CNT));
    wr(64'({fcsr_pkg::OP_WRNV, 16'hffff}), 24, 1'b0);
    rd(fcsr_pkg::OP_RDNV, 24, v);
    chk("persist locked", v, 16'h18e2);
    // Power-on again
    reset_and_defaults();
    end_of_test();
  end
endmodule
